// *** logic/iors_dev.sv ***
`timescale 1ns/1ps
// Operation
// - software writes zero to reserved bits
// - never write reserved i/o locations
// - bit set/clear only at 0x00-0x1F
// - bit test on lowest 32 locations
// - writing one clears status flags
// - bit set/clear touches only addressed bit
// - direct i/o decodes 0x00-0x3F
// - data-space alias at i/o plus 0x20
// - 0x60-0xFF only through data space; data accesses there are refused
// - eeprom address bits above top ignored
module iors_dev (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  iors_bus_if.dev          BUS,
  input  wire logic [7:0]  I_PORT_A_PINS,
  input  wire logic [7:0]  I_PORT_B_PINS,
  input  wire logic [1:0]  I_TIMER0_EVENTS,
  input  wire logic [2:0]  I_TIMER1_EVENTS,
  input  wire logic [1:0]  I_PIN_CHANGE_EVENTS,
  input  wire logic [1:0]  I_EXT_IRQ_EVENTS,
  input  wire logic [1:0]  I_SPI_STATUS,
  output logic      [7:0]  O_PORT_A_DIR,
  output logic      [7:0]  O_PORT_A_OUT,
  output logic      [7:0]  O_PORT_B_DIR,
  output logic      [7:0]  O_PORT_B_OUT,
  output logic      [8:0]  O_EEPROM_ADDR,
  output logic      [5:0]  O_EEPROM_CTRL,
  output logic      [7:0]  O_TIMER0_CTRL_A,
  output logic      [7:0]  O_TIMER0_CTRL_B,
  output logic      [7:0]  O_SPI_CTRL,
  output logic             O_EXT_IRQ_PENDING
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] pin_a_m_q;
  logic [7:0] pin_a_q;
  logic [7:0] pin_b_m_q;
  logic [7:0] pin_b_q;
  logic [1:0] spi_m_q;
  logic [1:0] spi_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      pin_a_m_q <= 8'h00;
      pin_a_q   <= 8'h00;
      pin_b_m_q <= 8'h00;
      pin_b_q   <= 8'h00;
      spi_m_q   <= 2'h0;
      spi_q     <= 2'h0;
    end else begin
      pin_a_m_q <= I_PORT_A_PINS;
      pin_a_q   <= pin_a_m_q;
      pin_b_m_q <= I_PORT_B_PINS;
      pin_b_q   <= pin_b_m_q;
      spi_m_q   <= I_SPI_STATUS;
      spi_q     <= spi_m_q;
    end
  end

  // ****************************************
  // access decode
  // ****************************************
  logic [7:0] regs_q [0:63];
  logic       ack_q;
  logic       take;
  logic [6:0] dec;
  logic       legal;
  logic [5:0] idx;
  logic       is_wr;
  logic       is_rd;
  logic [7:0] wd;
  logic [7:0] bmask;
  logic [7:0] rv;

  assign take  = BUS.req && !ack_q;
  assign dec   = iors_pkg::decode(BUS.op, BUS.addr);
  assign legal = dec[6];
  assign idx   = dec[5:0];

  always_comb begin
    is_wr = 1'b0;
    is_rd = 1'b0;
    wd    = BUS.wdata;
    bmask = 8'hFF;
    case (BUS.op)
      iors_pkg::OP_IO_WRITE, iors_pkg::OP_DATA_STORE: begin
        is_wr = 1'b1;
      end
      iors_pkg::OP_SET_SINGLE_IO_BIT: begin
        is_wr = 1'b1;
        wd    = 8'hFF;
        bmask = 8'h01 << BUS.bit_sel;
      end
      iors_pkg::OP_CLEAR_SINGLE_IO_BIT: begin
        is_wr = 1'b1;
        wd    = 8'h00;
        bmask = 8'h01 << BUS.bit_sel;
      end
      iors_pkg::OP_IO_READ, iors_pkg::OP_DATA_LOAD, iors_pkg::OP_SKIP_TEST: begin
        is_rd = 1'b1;
      end
      default: begin
        is_rd = 1'b0;
      end
    endcase
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    case (idx)
      iors_pkg::R_A_PINS:   rv = pin_a_q;
      iors_pkg::R_B_PINS:   rv = pin_b_q;
      iors_pkg::R_SPI_STAT: rv = {spi_q, 5'h00, regs_q[iors_pkg::R_SPI_STAT][0]};
      default:              rv = regs_q[idx] & iors_pkg::defined_bits(idx);
    endcase
  end

  // ****************************************
  // register update
  // ****************************************
  function automatic logic [7:0] next_val(
    input logic [7:0] old,
    input logic [5:0] i,
    input logic       hit,
    input logic [7:0] d,
    input logic [7:0] m,
    input logic [7:0] ev
  );
    logic [7:0] w1c;
    logic [7:0] wm;
    logic [7:0] n;
    w1c = iors_pkg::w1c_bits(i);
    wm  = iors_pkg::defined_bits(i) & ~w1c;
    if (i == iors_pkg::R_A_PINS || i == iors_pkg::R_B_PINS) begin
      wm = 8'h00;
    end
    if (i == iors_pkg::R_SPI_STAT) begin
      wm = 8'h01;
    end
    n = old;
    if (hit) begin
      n = (n & ~(m & wm)) | (d & m & wm);
      n = n & ~(d & m & w1c);
    end
    return n | (ev & w1c);
  endfunction

  logic [7:0] ev_set [0:63];

  always_comb begin
    for (int i = 0; i < 64; i++) begin
      ev_set[i] = 8'h00;
    end
    ev_set[iors_pkg::R_T0_FLAGS] = {6'h00, I_TIMER0_EVENTS};
    ev_set[iors_pkg::R_T1_FLAGS] = {2'h0, I_TIMER1_EVENTS[2], 4'h0, I_TIMER1_EVENTS[0]}
                                   | {5'h00, I_TIMER1_EVENTS[1], 2'h0};
    ev_set[iors_pkg::R_PC_FLAGS] = {6'h00, I_PIN_CHANGE_EVENTS};
    ev_set[iors_pkg::R_EX_FLAGS] = {6'h00, I_EXT_IRQ_EVENTS};
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= iors_pkg::RESET_VAL;
      end
    end else begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= next_val(regs_q[i], 6'(i), take && legal && is_wr && (idx == 6'(i)),
                              wd, bmask, ev_set[i]);
      end
    end
  end

  // ****************************************
  // answer
  // ****************************************
  logic [7:0] rdata_q;
  logic       bit_q;
  logic       err_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
      bit_q   <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q   <= !legal;
        rdata_q <= (legal && is_rd) ? rv : 8'h00;
        bit_q   <= legal && (BUS.op == iors_pkg::OP_SKIP_TEST) && rv[BUS.bit_sel];
      end
    end
  end

  assign BUS.ack     = ack_q;
  assign BUS.rdata   = rdata_q;
  assign BUS.bit_val = bit_q;
  assign BUS.err     = err_q;

  // ****************************************
  // register views
  // ****************************************
  logic [8:0] ee_raw;
  localparam logic [8:0] EE_MASK = 9'((1 << (iors_pkg::EE_TOP_BIT + 1)) - 1);

  assign ee_raw            = {regs_q[iors_pkg::R_EE_AHI][0], regs_q[iors_pkg::R_EE_ALO]};
  assign O_EEPROM_ADDR     = ee_raw & EE_MASK;
  assign O_EEPROM_CTRL     = regs_q[iors_pkg::R_EE_CTRL][5:0];
  assign O_PORT_A_DIR      = regs_q[iors_pkg::R_A_DIR];
  assign O_PORT_A_OUT      = regs_q[iors_pkg::R_A_OUT];
  assign O_PORT_B_DIR      = regs_q[iors_pkg::R_B_DIR];
  assign O_PORT_B_OUT      = regs_q[iors_pkg::R_B_OUT];
  assign O_TIMER0_CTRL_A   = regs_q[iors_pkg::R_T0_CTLA] & iors_pkg::defined_bits(iors_pkg::R_T0_CTLA);
  assign O_TIMER0_CTRL_B   = regs_q[iors_pkg::R_T0_CTLB] & iors_pkg::defined_bits(iors_pkg::R_T0_CTLB);
  assign O_SPI_CTRL        = regs_q[iors_pkg::R_SPI_CTL];
  assign O_EXT_IRQ_PENDING = |(regs_q[iors_pkg::R_EX_FLAGS] & regs_q[iors_pkg::R_EX_MASK]);

endmodule

// *** logic/iors_pkg.sv ***
package iors_pkg;

  // ****************************************
  // access kinds
  // ****************************************
  typedef enum logic [2:0] {
    OP_IO_READ,
    OP_IO_WRITE,
    OP_DATA_LOAD,
    OP_DATA_STORE,
    OP_SET_SINGLE_IO_BIT,
    OP_CLEAR_SINGLE_IO_BIT,
    OP_SKIP_TEST
  } iors_op_e;

  // ****************************************
  // address windows
  // ****************************************
  localparam logic [7:0] IO_TOP      = 8'h3F;
  localparam logic [7:0] BIT_TOP     = 8'h1F;
  localparam logic [7:0] DATA_IO_OFS = 8'h20;
  localparam logic [7:0] EXT_LOW     = 8'h60;

  // ****************************************
  // i/o register offsets
  // ****************************************
  localparam logic [5:0] R_A_PINS   = 6'h00;
  localparam logic [5:0] R_A_DIR    = 6'h01;
  localparam logic [5:0] R_A_OUT    = 6'h02;
  localparam logic [5:0] R_B_PINS   = 6'h03;
  localparam logic [5:0] R_B_DIR    = 6'h04;
  localparam logic [5:0] R_B_OUT    = 6'h05;
  localparam logic [5:0] R_PULLUP   = 6'h12;
  localparam logic [5:0] R_T0_FLAGS = 6'h15;
  localparam logic [5:0] R_T1_FLAGS = 6'h16;
  localparam logic [5:0] R_PC_FLAGS = 6'h1B;
  localparam logic [5:0] R_EX_FLAGS = 6'h1C;
  localparam logic [5:0] R_EX_MASK  = 6'h1D;
  localparam logic [5:0] R_GP0      = 6'h1E;
  localparam logic [5:0] R_EE_CTRL  = 6'h1F;
  localparam logic [5:0] R_EE_DATA  = 6'h20;
  localparam logic [5:0] R_EE_ALO   = 6'h21;
  localparam logic [5:0] R_EE_AHI   = 6'h22;
  localparam logic [5:0] R_PRESYNC  = 6'h23;
  localparam logic [5:0] R_T0_CTLA  = 6'h25;
  localparam logic [5:0] R_T0_CTLB  = 6'h26;
  localparam logic [5:0] R_T0_CNT   = 6'h27;
  localparam logic [5:0] R_T0_CMP   = 6'h28;
  localparam logic [5:0] R_GP1      = 6'h2A;
  localparam logic [5:0] R_GP2      = 6'h2B;
  localparam logic [5:0] R_SPI_CTL  = 6'h2C;
  localparam logic [5:0] R_SPI_STAT = 6'h2D;
  localparam logic [5:0] R_SPI_DATA = 6'h2E;

  localparam int         EE_TOP_BIT = 8;
  localparam logic [7:0] RESET_VAL  = 8'h00;

  // ****************************************
  // controller apb map
  // ****************************************
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_RESULT   = 8'h04;
  localparam logic [7:0] APB_IRQ_STAT = 8'h08;
  localparam logic [7:0] APB_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] APB_IRQ_EN   = 8'h10;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_BIT_LSB  = 16;
  localparam int CMD_OP_LSB   = 20;
  localparam int RES_BIT_POS  = 8;
  localparam int RES_ERR_POS  = 9;
  localparam int RES_BUSY_POS = 16;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERR      = 1;

  // ****************************************
  // map functions
  // ****************************************
  function automatic logic [7:0] defined_bits(input logic [5:0] idx);
    case (idx)
      R_PULLUP:                           return 8'h33;
      R_T0_FLAGS:                         return 8'h03;
      R_T1_FLAGS:                         return 8'h27;
      R_PC_FLAGS, R_EX_FLAGS, R_EX_MASK:  return 8'h03;
      R_EE_CTRL:                          return 8'h3F;
      R_EE_AHI:                           return 8'h01;
      R_PRESYNC:                          return 8'h83;
      R_T0_CTLA:                          return 8'hC3;
      R_T0_CTLB:                          return 8'h87;
      R_SPI_STAT:                         return 8'hC1;
      R_A_PINS, R_A_DIR, R_A_OUT, R_B_PINS, R_B_DIR, R_B_OUT, R_GP0, R_EE_DATA,
      R_EE_ALO, R_T0_CNT, R_T0_CMP, R_GP1, R_GP2, R_SPI_CTL, R_SPI_DATA:
                                          return 8'hFF;
      default:                            return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] w1c_bits(input logic [5:0] idx);
    case (idx)
      R_T0_FLAGS:             return 8'h03;
      R_T1_FLAGS:             return 8'h27;
      R_PC_FLAGS, R_EX_FLAGS: return 8'h03;
      default:                return 8'h00;
    endcase
  endfunction

  // returns {legal, io index}
  function automatic logic [6:0] decode(input iors_op_e op, input logic [7:0] addr);
    logic [7:0] t;
    logic       ok;
    t = addr - DATA_IO_OFS;
    if (op == OP_DATA_LOAD || op == OP_DATA_STORE) begin
      ok = (addr >= DATA_IO_OFS) && (addr < EXT_LOW);
      return {ok, t[5:0]};
    end
    ok = addr <= IO_TOP;
    if (op == OP_SET_SINGLE_IO_BIT || op == OP_CLEAR_SINGLE_IO_BIT || op == OP_SKIP_TEST) begin
      ok = addr <= BIT_TOP;
    end
    return {ok, addr[5:0]};
  endfunction

endpackage

// *** logic/iors_bus_if.sv ***
`timescale 1ns/1ps
interface iors_bus_if;
  logic                req;
  iors_pkg::iors_op_e  op;
  logic [7:0]          addr;
  logic [2:0]          bit_sel;
  logic [7:0]          wdata;
  logic                ack;
  logic [7:0]          rdata;
  logic                bit_val;
  logic                err;

  modport dev  (input req, op, addr, bit_sel, wdata, output ack, rdata, bit_val, err);
  modport core (output req, op, addr, bit_sel, wdata, input ack, rdata, bit_val, err);
endinterface

// *** logic/iors_core.sv ***
`timescale 1ns/1ps
module iors_core (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  iors_bus_if.core         BUS,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             O_IRQ
);

  // ****************************************
  // apb decode
  // ****************************************
  logic               wr_en;
  logic               req_q;
  iors_pkg::iors_op_e op_c;
  logic [7:0]         addr_c;
  logic [6:0]         dec;
  logic [7:0]         defd;
  logic               is_wr;
  logic               is_byte;
  logic               ok;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign op_c    = iors_pkg::iors_op_e'(pwdata[iors_pkg::CMD_OP_LSB +: 3]);
  assign addr_c  = pwdata[iors_pkg::CMD_ADDR_LSB +: 8];
  assign dec     = iors_pkg::decode(op_c, addr_c);
  assign defd    = iors_pkg::defined_bits(dec[5:0]);
  assign is_byte = (op_c == iors_pkg::OP_IO_WRITE) || (op_c == iors_pkg::OP_DATA_STORE);
  assign is_wr   = is_byte || (op_c == iors_pkg::OP_SET_SINGLE_IO_BIT)
                   || (op_c == iors_pkg::OP_CLEAR_SINGLE_IO_BIT);
  assign ok      = dec[6] && !(is_wr && defd == 8'h00) && (op_c <= iors_pkg::OP_SKIP_TEST);

  // ****************************************
  // request to register space
  // ****************************************
  logic               cmd_go;
  logic               refuse;
  iors_pkg::iors_op_e op_q;
  logic [7:0]         addr_q;
  logic [2:0]         bit_q;
  logic [7:0]         wdata_q;

  assign cmd_go = wr_en && (paddr == iors_pkg::APB_CMD) && !req_q;
  assign refuse = cmd_go && !ok;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      req_q   <= 1'b0;
      op_q    <= iors_pkg::OP_IO_READ;
      addr_q  <= 8'h00;
      bit_q   <= 3'h0;
      wdata_q <= 8'h00;
    end else if (cmd_go && ok) begin
      req_q   <= 1'b1;
      op_q    <= op_c;
      addr_q  <= addr_c;
      bit_q   <= pwdata[iors_pkg::CMD_BIT_LSB +: 3];
      wdata_q <= pwdata[7:0] & (is_byte ? defd : 8'hFF);
    end else if (BUS.ack) begin
      req_q <= 1'b0;
    end
  end

  assign BUS.req     = req_q;
  assign BUS.op      = op_q;
  assign BUS.addr    = addr_q;
  assign BUS.bit_sel = bit_q;
  assign BUS.wdata   = wdata_q;

  // ****************************************
  // result and interrupts
  // ****************************************
  logic [7:0] res_data_q;
  logic       res_bit_q;
  logic       res_err_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [1:0] ev;
  logic [1:0] clr;

  assign ev  = {refuse || (BUS.ack && BUS.err), BUS.ack};
  assign clr = (wr_en && paddr == iors_pkg::APB_IRQ_CLR) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      res_data_q <= 8'h00;
      res_bit_q  <= 1'b0;
      res_err_q  <= 1'b0;
    end else if (BUS.ack) begin
      res_data_q <= BUS.rdata;
      res_bit_q  <= BUS.bit_val;
      res_err_q  <= BUS.err;
    end else if (refuse) begin
      res_data_q <= 8'h00;
      res_bit_q  <= 1'b0;
      res_err_q  <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      irq_stat_q <= 2'h0;
      irq_en_q   <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      if (wr_en && paddr == iors_pkg::APB_IRQ_EN) begin
        irq_en_q <= pwdata[1:0];
      end
    end
  end

  assign O_IRQ = |(irq_stat_q & irq_en_q);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      iors_pkg::APB_RESULT: begin
        prdata[7:0]                     = res_data_q;
        prdata[iors_pkg::RES_BIT_POS]   = res_bit_q;
        prdata[iors_pkg::RES_ERR_POS]   = res_err_q;
        prdata[iors_pkg::RES_BUSY_POS]  = req_q;
      end
      iors_pkg::APB_IRQ_STAT: prdata[1:0] = irq_stat_q;
      iors_pkg::APB_IRQ_EN:   prdata[1:0] = irq_en_q;
      default:                prdata = 32'h0000_0000;
    endcase
  end

endmodule

// *** test/iors_link_asserts.sv ***
`timescale 1ns/1ps
module iors_link_asserts (
  input wire logic                I_CLK_SYS,
  input wire logic                I_RESET,
  input wire logic                req,
  input wire iors_pkg::iors_op_e  op,
  input wire logic [7:0]          addr,
  input wire logic [2:0]          bit_sel,
  input wire logic [7:0]          wdata,
  input wire logic                ack,
  input wire logic [7:0]          rdata,
  input wire logic                bit_val,
  input wire logic                err
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  // ****************************************
  // link steps
  // ****************************************
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ##1 ack ##1 (!ack && !req);
  endsequence

  // ****************************************
  // checks
  // ****************************************
  a_answer_next: assert property (s_taken |-> s_answer)
    else $error("link answer not one cycle after take");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (ack |-> req)
    else $error("ack without pending request");
  a_req_held: assert property (s_taken |=> $stable(op) && $stable(addr) && $stable(wdata)
                                         && $stable(bit_sel))
    else $error("request changed before ack");
  a_bit_range: assert property (req && op inside {iors_pkg::OP_SET_SINGLE_IO_BIT,
    iors_pkg::OP_CLEAR_SINGLE_IO_BIT, iors_pkg::OP_SKIP_TEST} |-> addr <= 8'h1F)
    else $error("bit access above low window");
  a_io_range: assert property (req && op inside {iors_pkg::OP_IO_READ, iors_pkg::OP_IO_WRITE}
                               |-> addr <= 8'h3F)
    else $error("direct access above io window");
  a_data_window: assert property (req && op inside {iors_pkg::OP_DATA_LOAD,
    iors_pkg::OP_DATA_STORE} |-> addr >= 8'h20 && addr < 8'h60)
    else $error("data alias outside window");
  a_no_err: assert property (ack |-> !err)
    else $error("error on a decodable access");
  a_skip_bit: assert property (ack && op == iors_pkg::OP_SKIP_TEST
                               |-> bit_val == rdata[bit_sel])
    else $error("tested bit differs from read value");
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, pend;
  logic [7:0]  paddr, pa_pins, pb_dir;
  logic [7:0]  pa_out, pb_ddr, pb_out, t0a, t0b, spi_ctl;
  logic [5:0]  ee_ctl;
  logic [2:0]  t1_ev;
  logic [1:0]  ex_ev;
  logic [8:0]  ee_addr;
  logic [31:0] pwdata, prdata, res, rd;
  int          miscompares, n_tests;

  iors_bus_if bus ();
  iors_core i_iors_core (.I_CLK_SYS(clk), .I_RESET(rst), .BUS(bus.core), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .O_IRQ(irq));
  iors_dev i_iors_dev (.I_CLK_SYS(clk), .I_RESET(rst), .BUS(bus.dev),
    .I_PORT_A_PINS(pa_pins), .I_PORT_B_PINS(~pa_pins), .I_TIMER0_EVENTS(t1_ev[1:0]),
    .I_TIMER1_EVENTS(t1_ev), .I_PIN_CHANGE_EVENTS(ex_ev), .I_EXT_IRQ_EVENTS(ex_ev),
    .I_SPI_STATUS(pa_pins[7:6]), .O_PORT_A_DIR(pb_dir), .O_PORT_A_OUT(pa_out),
    .O_PORT_B_DIR(pb_ddr), .O_PORT_B_OUT(pb_out), .O_EEPROM_ADDR(ee_addr),
    .O_EEPROM_CTRL(ee_ctl), .O_TIMER0_CTRL_A(t0a), .O_TIMER0_CTRL_B(t0b),
    .O_SPI_CTRL(spi_ctl), .O_EXT_IRQ_PENDING(pend));
  iors_link_asserts i_iors_link_asserts (.I_CLK_SYS(clk), .I_RESET(rst), .req(bus.req),
    .op(bus.op), .addr(bus.addr), .bit_sel(bus.bit_sel), .wdata(bus.wdata), .ack(bus.ack),
    .rdata(bus.rdata), .bit_val(bus.bit_val), .err(bus.err));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk(pslverr, 1'b0);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic cmd(input iors_pkg::iors_op_e op, input logic [7:0] a,
                     input logic [2:0] b, input logic [7:0] wd);
    int n;
    n = 0;
    apb(1'b1, 8'h00, {9'h000, op, 1'b0, b, a, wd});
    do begin
      apb(1'b0, 8'h04, 32'h0000_0000);
      n++;
    end while (rd[16] !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("wrong value at %0t: command stayed busy", $time);
    end
    res = rd;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  // ****************************************
  // tests
  // ****************************************
  iors_pkg::iors_op_e bad_op [7] = '{iors_pkg::OP_IO_READ, iors_pkg::OP_DATA_LOAD,
    iors_pkg::OP_DATA_LOAD, iors_pkg::OP_SET_SINGLE_IO_BIT, iors_pkg::OP_SKIP_TEST,
    iors_pkg::OP_CLEAR_SINGLE_IO_BIT, iors_pkg::OP_IO_WRITE};
  logic [7:0] bad_adr [7] = '{8'h40, 8'h60, 8'h1F, 8'h20, 8'h21, 8'h3F, 8'h07};

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pa_pins = 8'h00; t1_ev = 3'b000; ex_ev = 2'b00;
    miscompares = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // byte access and data alias
    cmd(iors_pkg::OP_IO_WRITE, 8'h1E, 3'h0, 8'hA5);
    chk(irq, 1'b0);
    cmd(iors_pkg::OP_DATA_LOAD, 8'h3E, 3'h0, 8'h00);
    chk(res[9:0], 10'h0A5);
    cmd(iors_pkg::OP_DATA_STORE, 8'h4A, 3'h0, 8'h5A);
    cmd(iors_pkg::OP_IO_READ, 8'h2A, 3'h0, 8'h00);
    chk(res[9:0], 10'h05A);
    // refused accesses raise the error interrupt
    apb(1'b1, 8'h10, 32'h0000_0002);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      cmd(bad_op[i], bad_adr[i], 3'h0, 8'h00);
      chk(res[9], 1'b1);
    end
    cmd(iors_pkg::iors_op_e'(3'h7), 8'h1E, 3'h0, 8'h00);
    chk(res[9], 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, 8'h0C, 32'h0000_0003);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1'b1, 8'h10, 32'h0000_0001);
    cmd(iors_pkg::OP_IO_READ, 8'h07, 3'h0, 8'h00);
    chk(irq, 1'b1);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // single bit set and clear
    cmd(iors_pkg::OP_SET_SINGLE_IO_BIT, 8'h01, 3'h3, 8'h00);
    chk(pb_dir, 8'h08);
    cmd(iors_pkg::OP_IO_WRITE, 8'h01, 3'h0, 8'hF0);
    cmd(iors_pkg::OP_SET_SINGLE_IO_BIT, 8'h01, 3'h0, 8'h00);
    chk(pb_dir, 8'hF1);
    cmd(iors_pkg::OP_CLEAR_SINGLE_IO_BIT, 8'h01, 3'h4, 8'h00);
    chk(pb_dir, 8'hE1);
    // write-one-to-clear flags
    @(posedge clk) t1_ev <= 3'b111;
    @(posedge clk) t1_ev <= 3'b000;
    cmd(iors_pkg::OP_IO_READ, 8'h16, 3'h0, 8'h00);
    chk(res[7:0], 8'h25);
    cmd(iors_pkg::OP_IO_READ, 8'h15, 3'h0, 8'h00);
    chk(res[7:0], 8'h03);
    cmd(iors_pkg::OP_SET_SINGLE_IO_BIT, 8'h16, 3'h2, 8'h00);
    cmd(iors_pkg::OP_CLEAR_SINGLE_IO_BIT, 8'h16, 3'h0, 8'h00);
    cmd(iors_pkg::OP_IO_READ, 8'h16, 3'h0, 8'h00);
    chk(res[7:0], 8'h21);
    cmd(iors_pkg::OP_IO_WRITE, 8'h16, 3'h0, 8'h01);
    cmd(iors_pkg::OP_IO_WRITE, 8'h16, 3'h0, 8'h00);
    cmd(iors_pkg::OP_IO_READ, 8'h16, 3'h0, 8'h00);
    chk(res[7:0], 8'h20);
    @(posedge clk) ex_ev <= 2'b01;
    @(posedge clk) ex_ev <= 2'b00;
    cmd(iors_pkg::OP_IO_WRITE, 8'h1D, 3'h0, 8'h01);
    chk(pend, 1'b1);
    cmd(iors_pkg::OP_SET_SINGLE_IO_BIT, 8'h1C, 3'h0, 8'h00);
    chk(pend, 1'b0);
    cmd(iors_pkg::OP_IO_READ, 8'h1B, 3'h0, 8'h00);
    chk(res[7:0], 8'h01);
    cmd(iors_pkg::OP_IO_WRITE, 8'h1B, 3'h0, 8'h01);
    cmd(iors_pkg::OP_IO_READ, 8'h1B, 3'h0, 8'h00);
    chk(res[7:0], 8'h00);
    // bit test on pins
    @(posedge clk) pa_pins <= 8'h81;
    repeat (3) @(posedge clk);
    cmd(iors_pkg::OP_SKIP_TEST, 8'h00, 3'h7, 8'h00);
    chk(res[9:8], 2'b01);
    cmd(iors_pkg::OP_SKIP_TEST, 8'h00, 3'h1, 8'h00);
    chk(res[9:8], 2'b00);
    cmd(iors_pkg::OP_IO_READ, 8'h03, 3'h0, 8'h00);
    chk(res[7:0], 8'h7E);
    cmd(iors_pkg::OP_DATA_LOAD, 8'h4D, 3'h0, 8'h00);
    chk(res[7:0], 8'h80);
    // byte registers reach their outputs
    cmd(iors_pkg::OP_IO_WRITE, 8'h02, 3'h0, 8'h3C);
    cmd(iors_pkg::OP_IO_WRITE, 8'h04, 3'h0, 8'h96);
    cmd(iors_pkg::OP_DATA_STORE, 8'h25, 3'h0, 8'h69);
    chk({pa_out, pb_ddr, pb_out}, 24'h3C_9669);
    cmd(iors_pkg::OP_IO_WRITE, 8'h1F, 3'h0, 8'hFF);
    cmd(iors_pkg::OP_IO_WRITE, 8'h25, 3'h0, 8'hFF);
    cmd(iors_pkg::OP_IO_WRITE, 8'h26, 3'h0, 8'hFF);
    cmd(iors_pkg::OP_DATA_STORE, 8'h4C, 3'h0, 8'hA7);
    chk({ee_ctl, t0a, t0b, spi_ctl}, 30'h3FC3_87A7);
    // eeprom address masking and reserved reads
    cmd(iors_pkg::OP_IO_WRITE, 8'h22, 3'h0, 8'hFF);
    cmd(iors_pkg::OP_IO_WRITE, 8'h21, 3'h0, 8'h34);
    chk(ee_addr, 9'h134);
    cmd(iors_pkg::OP_IO_READ, 8'h22, 3'h0, 8'h00);
    chk(res[9:0], 10'h001);
    cmd(iors_pkg::OP_IO_READ, 8'h07, 3'h0, 8'h00);
    chk(res[9:0], 10'h000);
    // mid-run reset clears the register space
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({pb_dir, ee_addr, pend, irq}, 19'h0_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    cmd(iors_pkg::OP_IO_READ, 8'h1E, 3'h0, 8'h00);
    chk(res[9:0], 10'h000);
    wrap_up();
  end
endmodule
